// ==== verilog/hpc_pkg.sv ====
// constants for the host port and control word access block
package hpc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int CW_NUM = 256;
  localparam int CW_X_W = 8;
  localparam int SUBCH_NUM = 64;
  localparam int SEQ_W = 4;
  localparam int SEQ_MAX = 12;
  localparam int REG_IDX_W = 14;
  // register word indices
  localparam logic [13:0] REG_CTRL_INDEX = 14'h0000;
  localparam logic [13:0] REG_RX_CTRL = 14'h0001;
  localparam logic [13:0] REG_TX_CTRL = 14'h0002;
  localparam logic [13:0] REG_LAYER1_SETUP = 14'h0003;
  localparam logic [13:0] REG_IRQ_STATUS = 14'h0004;
  localparam logic [13:0] REG_IRQ_ENABLE = 14'h0005;
  // control index field positions
  localparam int RX_X_LSB = 0;
  localparam int RX_SEQ_LSB = 8;
  localparam int TX_X_LSB = 16;
  localparam int TX_SEQ_LSB = 24;
  localparam logic [31:0] INDEX_MASK = 32'h0FFF_0FFF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int L1_TXCW_EN_BIT = 0;
  localparam int IRQ_NUM = 8;
endpackage

// ==== verilog/hpc_cw_mem.sv ====
// control word section store, byte-enable write, combinational read
`timescale 1ns/1ns
`default_nettype none
module hpc_cw_mem #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [DW/8-1:0] wrByteEn,
  // read side
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  assign rdData = mem[rdAddr];

  // no reset: contents are link data, a reset would cost a full sweep
  // one process for all lanes, so the array keeps a single driver
  always_ff @(posedge clk) begin
    for (int b = 0; b < DW/8; b++) begin
      if (wrEn && wrByteEn[b]) begin
        mem[wrAddr][b*8 +: 8] <= wrData[b*8 +: 8];
      end
    end
  end
endmodule // hpc_cw_mem
`default_nettype wire

// ==== verilog/hpc_host_port.sv ====
// host register port with indexed hyperframe control word access
`timescale 1ns/1ns
`default_nettype none
module hpc_host_port
  import hpc_pkg::*;
#(
  parameter bit BYTE_ADDR = 1'b0,
  parameter bit CW_ACCESS = 1'b1,
  parameter int SECTIONS = SEQ_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host register port
  input wire logic [ADDR_W-1:0] hostAddress,
  input wire logic [BE_W-1:0] hostByteEn,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [DATA_W-1:0] hostWriteData,
  output logic [DATA_W-1:0] hostReadData,
  output logic hostWaitReq,
  output logic hostIrq,
  // interrupt sources
  input wire logic [IRQ_NUM-1:0] irqEvent,
  // receive control word fill from the link
  input wire logic rxCwWrite,
  input wire logic [CW_X_W-1:0] rxCwIndex,
  input wire logic [SEQ_W-1:0] rxCwSeq,
  input wire logic [DATA_W-1:0] rxCwData,
  // transmit control word fetch by the link
  input wire logic [CW_X_W-1:0] txCwIndex,
  input wire logic [SEQ_W-1:0] txCwSeq,
  output logic [DATA_W-1:0] txCwData,
  output logic txCwEnable,
  output logic [DATA_W-1:0] layer1Setup
);
  localparam int MAW = SEQ_W + CW_X_W;

  generate
    if (SECTIONS < 1 || SECTIONS > (1 << SEQ_W)) begin : gBadSections
      $error("SECTIONS must be 1 to 16");
    end
    if (CW_NUM != SUBCH_NUM * 4) begin : gBadLayout
      $error("control words must be 64 subchannels of four");
    end
  endgenerate

  logic [DATA_W-1:0] ctrlIndex;
  logic [DATA_W-1:0] irqStatus;
  logic [DATA_W-1:0] irqEnable;
  logic readPending;

  // address decode, word or byte addressed
  wire [REG_IDX_W-1:0] regIdx = BYTE_ADDR ?
    hostAddress[ADDR_W-1:2] : hostAddress[REG_IDX_W-1:0];
  wire hiBitsZero = BYTE_ADDR ? 1'b1 : (hostAddress[15:14] == 2'b00);
  wire selIndex = hiBitsZero && regIdx == REG_CTRL_INDEX;
  wire selRx = hiBitsZero && regIdx == REG_RX_CTRL && CW_ACCESS;
  wire selTx = hiBitsZero && regIdx == REG_TX_CTRL && CW_ACCESS;
  wire selL1 = hiBitsZero && regIdx == REG_LAYER1_SETUP;
  wire selIrqSt = hiBitsZero && regIdx == REG_IRQ_STATUS;
  wire selIrqEn = hiBitsZero && regIdx == REG_IRQ_ENABLE;
  wire wrStb = hostWrite && !hostRead;

  // byte lane mask from the enables
  wire [DATA_W-1:0] laneMask = {{8{hostByteEn[3]}}, {8{hostByteEn[2]}},
    {8{hostByteEn[1]}}, {8{hostByteEn[0]}}};

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old);
    merge = (old & ~laneMask) | (hostWriteData & laneMask);
  endfunction

  // index fields; word index X already equals Ns + 64 * Xs
  wire [CW_X_W-1:0] rxX = ctrlIndex[RX_X_LSB +: CW_X_W];
  wire [SEQ_W-1:0] rxSeq = ctrlIndex[RX_SEQ_LSB +: SEQ_W];
  wire [CW_X_W-1:0] txX = ctrlIndex[TX_X_LSB +: CW_X_W];
  wire [SEQ_W-1:0] txSeq = ctrlIndex[TX_SEQ_LSB +: SEQ_W];

  // receive table: link fills, host reads the indexed section
  logic [DATA_W-1:0] rxSection;
  hpc_cw_mem #(.AW(MAW), .DW(DATA_W)) uRxTable (
    .clk(clk),
    .wrEn(rxCwWrite),
    .wrAddr({rxCwSeq, rxCwIndex}),
    .wrData(rxCwData),
    .wrByteEn(4'hF),
    .rdAddr({rxSeq, rxX}),
    .rdData(rxSection)
  );

  // transmit table: host writes sections, link fetches them
  logic [DATA_W-1:0] txSection;
  // one extra bit so that SECTIONS = 16 does not wrap to zero
  wire txWrEn = wrStb && selTx &&
    ({1'b0, txSeq} < (SEQ_W+1)'(SECTIONS));
  hpc_cw_mem #(.AW(MAW), .DW(DATA_W)) uTxTable (
    .clk(clk),
    .wrEn(txWrEn),
    .wrAddr({txSeq, txX}),
    .wrData(hostWriteData),
    .wrByteEn(hostByteEn),
    .rdAddr({txCwSeq, txCwIndex}),
    .rdData(txSection)
  );

  // read selection, unmapped addresses answer zero
  wire [DATA_W-1:0] rdMux =
    selIndex ? ctrlIndex :
    selRx ? rxSection :
    selTx ? RST_WORD :
    selL1 ? layer1Setup :
    selIrqSt ? irqStatus :
    selIrqEn ? irqEnable : RST_WORD;

  // sticky status: set wins over a write-one-to-clear in the same cycle
  wire [DATA_W-1:0] irqClr = (wrStb && selIrqSt) ?
    (hostWriteData & laneMask) : RST_WORD;
  wire [DATA_W-1:0] next_irqStatus =
    (irqStatus & ~irqClr) | {{(DATA_W-IRQ_NUM){1'b0}}, irqEvent};
  // irq follows a new enable at once, not one cycle late
  wire [DATA_W-1:0] next_irqEnable = (wrStb && selIrqEn) ?
    (merge(irqEnable) & {{(DATA_W-IRQ_NUM){1'b0}}, {IRQ_NUM{1'b1}}}) :
    irqEnable;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlIndex <= RST_WORD;
      layer1Setup <= RST_WORD;
      irqEnable <= RST_WORD;
      irqStatus <= RST_WORD;
    end else begin
      irqStatus <= next_irqStatus;
      if (wrStb && selIndex) begin
        ctrlIndex <= merge(ctrlIndex) & INDEX_MASK;
      end
      if (wrStb && selL1) begin
        layer1Setup <= merge(layer1Setup);
      end
      irqEnable <= next_irqEnable;
    end
  end

  // one wait cycle on reads, none on writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readPending <= 1'b0;
      hostReadData <= RST_WORD;
    end else begin
      readPending <= hostRead && !readPending;
      if (hostRead && !readPending) begin
        hostReadData <= rdMux;
      end
    end
  end

  assign hostWaitReq = hostRead && !readPending;

  // no cause on the pin: software reads the status word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostIrq <= 1'b0;
    end else begin
      hostIrq <= |(next_irqStatus & next_irqEnable);
    end
  end

  // link side fetch, registered for timing towards the framer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txCwData <= RST_WORD;
    end else begin
      txCwData <= CW_ACCESS ? txSection : RST_WORD;
    end
  end

  assign txCwEnable = CW_ACCESS && layer1Setup[L1_TXCW_EN_BIT];
endmodule // hpc_host_port
`default_nettype wire

// ==== tb/hpc_host_port_properties.sv ====
// timing checks on the host port pins
`timescale 1ns/1ns
`default_nettype none
module hpc_host_port_chk
  import hpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host side
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [DATA_W-1:0] hostReadData,
  input wire logic hostWaitReq,
  input wire logic hostIrq,
  input wire logic [IRQ_NUM-1:0] irqEvent,
  // setup
  input wire logic txCwEnable,
  input wire logic [DATA_W-1:0] layer1Setup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence readStart; hostRead && hostWaitReq; endsequence
  sequence readDone; hostRead && !hostWaitReq; endsequence
  a_read_starts_wait: assert property ($rose(hostRead) |-> hostWaitReq)
    else $error("read began without wait");
  a_read_one_wait: assert property (readStart ##1 hostRead |-> readDone)
    else $error("read wait longer than one cycle");
  a_write_no_wait: assert property (hostWrite && !hostRead |-> !hostWaitReq)
    else $error("write stalled");
  a_wait_only_read: assert property (hostWaitReq |-> hostRead)
    else $error("wait without read");
  a_data_holds: assert property (!readStart |=> $stable(hostReadData))
    else $error("read data moved without read");
  a_txen_tracks: assert property (txCwEnable == layer1Setup[0])
    else $error("transmit enable differs from setup");
  a_setup_by_write: assert property (!hostWrite |=> $stable(layer1Setup))
    else $error("setup changed without write");
  a_irq_steady: assert property (!hostWrite && irqEvent == '0 |=> $stable(hostIrq))
    else $error("irq moved without cause");
endmodule // hpc_host_port_chk
bind hpc_host_port hpc_host_port_chk i_chk (.*);
`default_nettype wire

// ==== tb/hpc_host_model.sv ====
// processor model driving the host register port
`timescale 1ns/1ns
`default_nettype none
module hpc_host_model
  import hpc_pkg::*;
(
  // clock
  input wire logic clk,
  // bus toward the port
  output logic [ADDR_W-1:0] hostAddress,
  output logic [BE_W-1:0] hostByteEn,
  output logic hostRead,
  output logic hostWrite,
  output logic [DATA_W-1:0] hostWriteData,
  input wire logic [DATA_W-1:0] hostReadData,
  input wire logic hostWaitReq
);
  initial begin
    hostAddress = '0;
    hostByteEn = '0;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    hostWriteData = '0;
  end
  task automatic wr(input logic [13:0] r, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge clk);
    hostAddress <= {2'b00, r};
    hostByteEn <= be;
    hostWriteData <= d;
    hostWrite <= 1'b1;
    @(posedge clk);
    hostWrite <= 1'b0;
    // released data must not keep showing the last word
    hostWriteData <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    hostAddress <= a;
    hostRead <= 1'b1;
    // data is taken at the edge where wait is sampled low
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (!hostWaitReq) break;
    end
    d = hostReadData;
    hostRead <= 1'b0;
  endtask
endmodule // hpc_host_model
`default_nettype wire

// ==== tb/hpc_host_port_tb_top.sv ====
// self-checking bench for the host port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; $display("FAIL %s exp %h got %h", n, e, g); end end
module hpc_host_port_tb_top
  import hpc_pkg::*;
;
  logic clk, sys_rst, hostRead, hostWrite, hostWaitReq, hostIrq, rxCwWrite;
  logic txCwEnable;
  logic [ADDR_W-1:0] hostAddress;
  logic [BE_W-1:0] hostByteEn;
  logic [DATA_W-1:0] hostWriteData, hostReadData, rxCwData, txCwData;
  logic [DATA_W-1:0] layer1Setup, rdv;
  logic [IRQ_NUM-1:0] irqEvent;
  logic [CW_X_W-1:0] rxCwIndex, txCwIndex, x;
  logic [SEQ_W-1:0] rxCwSeq, txCwSeq, s;
  int miscompares = 0;
  int totalChecks = 0;
  int cycles = 0;
  hpc_host_port i_hpc_host_port (.*);
  hpc_host_model i_hpc_host_model (.*);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rdchk(string n, logic [13:0] r, logic [31:0] e);
    i_hpc_host_model.rd({2'b00, r}, rdv);
    `CHK(n, e, rdv)
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, tests need about a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    {sys_rst, rxCwWrite, rxCwIndex, rxCwSeq, rxCwData} = '1;
    {irqEvent, txCwIndex, txCwSeq} = '0;
    rxCwWrite = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    i_hpc_host_model.wr(REG_CTRL_INDEX, 32'hFFFF_FFFF, 4'hF);
    rdchk("index", REG_CTRL_INDEX, 32'h0FFF_0FFF);
    i_hpc_host_model.wr(REG_LAYER1_SETUP, 32'h1234_5679, 4'hF);
    i_hpc_host_model.wr(REG_LAYER1_SETUP, 32'hAAAA_AAAA, 4'h5);
    rdchk("setup", REG_LAYER1_SETUP, 32'h12AA_56AA);
    `CHK("setupPin", 32'h12AA_56AA, layer1Setup)
    rdchk("unmapped", 14'h3FFF, 32'h0000_0000);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      x = 8'(1 + 64 * (k / 2));
      s = (k % 2 == 1) ? 4'(SEQ_MAX - 1) : 4'h0;
      @(posedge clk);
      {rxCwWrite, rxCwIndex, rxCwSeq} <= {1'b1, x, s};
      rxCwData <= {16'hC0DE, 4'h0, s, x};
      @(posedge clk);
      rxCwWrite <= 1'b0;
      i_hpc_host_model.wr(REG_CTRL_INDEX, {20'h0_0000, s, x}, 4'hF);
      rdchk("rxWord", REG_RX_CTRL, {16'hC0DE, 4'h0, s, x});
    end
    $display("test receive words done");
    i_hpc_host_model.wr(REG_CTRL_INDEX, 32'h0241_0000, 4'hF);
    i_hpc_host_model.wr(REG_TX_CTRL, 32'h5A5A_F00D, 4'hF);
    i_hpc_host_model.wr(REG_LAYER1_SETUP, 32'h0000_0001, 4'h1);
    @(posedge clk);
    {txCwIndex, txCwSeq} <= {8'h41, 4'h2};
    @(posedge clk);
    @(negedge clk);
    `CHK("txWord", 32'h5A5A_F00D, txCwData)
    `CHK("txEn", 1'b1, txCwEnable)
    $display("test transmit word done");
    i_hpc_host_model.wr(REG_IRQ_ENABLE, 32'h0000_0001, 4'hF);
    @(posedge clk);
    irqEvent <= 8'h03;
    @(posedge clk);
    irqEvent <= 8'h00;
    @(negedge clk);
    `CHK("irqHigh", 1'b1, hostIrq)
    rdchk("irqStat", REG_IRQ_STATUS, 32'h0000_0003);
    i_hpc_host_model.wr(REG_IRQ_STATUS, 32'h0000_0001, 4'h1);
    @(negedge clk);
    `CHK("irqMasked", 1'b0, hostIrq)
    rdchk("irqLeft", REG_IRQ_STATUS, 32'h0000_0002);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule // hpc_host_port_tb_top
`default_nettype wire
